// file: inc/swrc_pkg.sv
// Package for the sleep, wakeup and reset sequencer: register map, fields, timing
package swrc_pkg;

  // Register word offsets: printed offsets are even, not all multiples of four, so each is an index
  localparam logic [15:0] CPU_SPEED_IDX   = 16'hC008;
  localparam logic [15:0] POWER_CTRL_IDX  = 16'hC00A;
  localparam logic [15:0] WAKE_EN_IDX     = 16'hC00C;
  localparam logic [15:0] IRQ_STAT_IDX    = 16'hC00E;
  localparam logic [15:0] IRQ_MASK_IDX    = 16'hC010;
  localparam logic [15:0] SEQ_STAT_IDX    = 16'hC012;
  localparam logic [15:0] USB_A_IDX       = 16'hC090;
  localparam logic [15:0] USB_B_IDX       = 16'hC0B0;
  localparam int          ADDR_W          = 18;

  // Power control fields
  localparam int SLEEP_BIT = 1;

  // Wakeup source bit positions, shared by wake enable, status and mask
  localparam int NUM_WAKE      = 8;
  localparam int WK_USB_RESUME = 0;
  localparam int WK_BUS_POWER  = 1;
  localparam int WK_IDENTITY   = 2;
  localparam int WK_HPI_READ   = 3;
  localparam int WK_FSP_READ   = 4;
  localparam int WK_SPI_READ   = 5;
  localparam int WK_IRQ_ONE    = 6;
  localparam int WK_IRQ_ZERO   = 7;

  // Reset values
  localparam logic [15:0] CPU_SPEED_RST  = 16'h0000;
  localparam logic [15:0] POWER_CTRL_RST = 16'h0000;
  localparam logic [15:0] WAKE_EN_RST    = 16'h0000;
  localparam logic [15:0] USB_REG_RST    = 16'h0000;
  localparam logic [15:0] BOOT_VECTOR    = 16'hFF00;
  localparam logic [15:0] FIRMWARE_START = 16'hE000;
  localparam int          CPU_SPEED_W    = 4;

  // Timing
  localparam int SYS_CLK_MHZ     = 100;
  localparam int REF_CLK_MHZ     = 12;
  localparam int SETTLE_US       = 200;
  localparam int SETTLE_REF_CYC  = SETTLE_US * REF_CLK_MHZ;
  localparam int RESET_REF_CYC   = 16;

  // Sequencer states
  typedef enum logic [1:0] {
    SWRC_SETTLE = 2'b00,
    SWRC_RUN    = 2'b01,
    SWRC_SLEEP  = 2'b10
  } swrc_state_t;

  // Power-domain controls that travel together
  typedef struct packed {
    logic crystal_drive_en;
    logic pll_en;
    logic booster_en;
    logic transceiver_en;
  } swrc_power_t;

endpackage

// file: src/swrc_top.sv
// Sleep, wakeup and reset sequencer with its control registers on Avalon-MM
// Behaviour
// - Setting bit 1 of the power control register sends the device to sleep.
// - During sleep the general-purpose pin configuration is frozen at its value on entry.
// - During sleep every external memory address output is driven low.
// - Entering sleep stops the crystal drive, the PLL, the booster and the USB transceivers.
// - In sleep the processor stays suspended until an enabled wakeup event occurs.
// - Enabled wakeups include any identity-input edge, bus-power level, and any edge of either external IRQ.
// - Enabled wakeups also include USB resume and a read on the host port, fast serial or SPI port.
// - After a wakeup the PLL restarts and the processor resumes just over 200 us later, on the reference tick after the 2400th.
// - A pin reset returns every register to its power-on default.
// - After reset the processor starts 200 us later at 0xFF00, which jumps to 0xE000.
// - A USB bus reset changes only the two USB registers and nothing else.
// - Firmware can lower the processor clock through the speed register without touching peripheral timing.
// - The clock source select input is caught after reset to choose the reference.
`timescale 1ns/1ps

module swrc_top #(
  parameter int SETTLE_TICKS = swrc_pkg::SETTLE_REF_CYC,
  parameter int GPIO_W       = 32,
  parameter int REF_DIV      = 8
)(
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  // Avalon-MM slave, 16-bit registers in the low half
  input  wire logic [swrc_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  output logic [1:0]                       avs_response,
  // Reference tick, one pulse per 12 MHz period
  input  wire logic                        ref_tick,
  input  wire logic                        clock_source_select,
  // Wakeup sources
  input  wire logic                        usb_resume,
  input  wire logic                        otg_bus_power_sense,
  input  wire logic                        otg_identity_sense,
  input  wire logic                        host_port_interface_read,
  input  wire logic                        fast_serial_port_read,
  input  wire logic                        spi_read,
  input  wire logic                        external_irq_one,
  input  wire logic                        external_irq_zero,
  input  wire logic                        usb_bus_reset,
  // Pins and power domains
  input  wire logic [GPIO_W-1:0]           gpio_cfg_live,
  output logic      [GPIO_W-1:0]           gpio_cfg_hold,
  input  wire logic [swrc_pkg::ADDR_W:0]   mem_addr_live,
  output logic      [swrc_pkg::ADDR_W:0]   mem_addr_out,
  output swrc_pkg::swrc_power_t            power_en,
  output logic                             cpu_run,
  output logic [15:0]                      cpu_start_addr,
  output logic [swrc_pkg::CPU_SPEED_W-1:0] cpu_clk_div,
  output logic                             ref_is_12mhz,
  output logic                             irq
);

  // ==========================================================
  // Elaboration checks; a settle count of zero would release the core with no lock time
  if (SETTLE_TICKS < 1 || GPIO_W < 1 || REF_DIV < 1)
  begin : g_param_check
    $error("swrc_top: parameter out of range");
  end

  localparam int CNT_W = $clog2(SETTLE_TICKS + 1);

  // ==========================================================
  // Registers and state
  swrc_pkg::swrc_state_t state;
  logic [15:0]           cpu_speed;
  logic [15:0]           power_ctrl;
  logic [15:0]           wake_en;
  logic [swrc_pkg::NUM_WAKE-1:0] irq_stat;
  logic [swrc_pkg::NUM_WAKE-1:0] irq_mask;
  logic [15:0]           usb_a;
  logic [15:0]           usb_b;
  logic [CNT_W-1:0]      settle_cnt;
  logic                  strap_taken;
  logic                  id_q;
  logic                  external_irq_one_q;
  logic                  external_irq_zero_q;
  logic                  resp_pending;

  // ==========================================================
  // Bus decode
  wire logic [15:0] word_idx  = {avs_address[swrc_pkg::ADDR_W-2:2], 1'b0};
  wire logic        req       = (avs_read | avs_write) & ~resp_pending;
  wire logic        wr        = avs_write & ~resp_pending & (avs_byteenable[1:0] != 2'b00);
  wire logic [15:0] wmask     = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic [15:0] wdat      = avs_writedata[15:0];
  wire logic        hit_speed = word_idx == swrc_pkg::CPU_SPEED_IDX;
  wire logic        hit_power = word_idx == swrc_pkg::POWER_CTRL_IDX;
  wire logic        hit_wake  = word_idx == swrc_pkg::WAKE_EN_IDX;
  wire logic        hit_stat  = word_idx == swrc_pkg::IRQ_STAT_IDX;
  wire logic        hit_mask  = word_idx == swrc_pkg::IRQ_MASK_IDX;
  wire logic        hit_seq   = word_idx == swrc_pkg::SEQ_STAT_IDX;
  wire logic        hit_usb_a = word_idx == swrc_pkg::USB_A_IDX;
  wire logic        hit_usb_b = word_idx == swrc_pkg::USB_B_IDX;
  wire logic        mapped    = hit_speed | hit_power | hit_wake | hit_stat | hit_mask | hit_seq | hit_usb_a | hit_usb_b;

  // ==========================================================
  // Wakeup event detection
  wire logic [swrc_pkg::NUM_WAKE-1:0] wake_evt;
  assign wake_evt[swrc_pkg::WK_USB_RESUME] = usb_resume;
  assign wake_evt[swrc_pkg::WK_BUS_POWER]  = otg_bus_power_sense;
  assign wake_evt[swrc_pkg::WK_IDENTITY]   = otg_identity_sense ^ id_q;
  assign wake_evt[swrc_pkg::WK_HPI_READ]   = host_port_interface_read;
  assign wake_evt[swrc_pkg::WK_FSP_READ]   = fast_serial_port_read;
  assign wake_evt[swrc_pkg::WK_SPI_READ]   = spi_read;
  assign wake_evt[swrc_pkg::WK_IRQ_ONE]    = external_irq_one ^ external_irq_one_q;
  assign wake_evt[swrc_pkg::WK_IRQ_ZERO]   = external_irq_zero ^ external_irq_zero_q;
  wire logic [swrc_pkg::NUM_WAKE-1:0] wake_hit = wake_evt & wake_en[swrc_pkg::NUM_WAKE-1:0];
  wire logic wake_now  = (state == swrc_pkg::SWRC_SLEEP) & (|wake_hit);
  wire logic sleep_req = wr & hit_power & wmask[swrc_pkg::SLEEP_BIT] & wdat[swrc_pkg::SLEEP_BIT];
  wire logic settle_done = (settle_cnt == CNT_W'(SETTLE_TICKS)) & ref_tick;

  // Edge history; sampled every cycle so edges are seen in any state
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      id_q   <= 1'b0;
      external_irq_one_q <= 1'b0;
      external_irq_zero_q <= 1'b0;
    end
    else
    begin
      id_q   <= otg_identity_sense;
      external_irq_one_q <= external_irq_one;
      external_irq_zero_q <= external_irq_zero;
    end
  end

  // ==========================================================
  // Sequencer: settle after reset or wake, run, sleep
  swrc_pkg::swrc_state_t next_state;
  always_comb
  begin
    next_state = state;
    case (state)
      swrc_pkg::SWRC_SETTLE: if (settle_done) next_state = swrc_pkg::SWRC_RUN;
      swrc_pkg::SWRC_RUN:    if (sleep_req) next_state = swrc_pkg::SWRC_SLEEP;
      swrc_pkg::SWRC_SLEEP:  if (wake_now) next_state = swrc_pkg::SWRC_SETTLE;
      default:               next_state = swrc_pkg::SWRC_SETTLE;
    endcase
  end

  // Settle counter advances only on reference ticks, so it tracks the crystal not sys_clk
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= swrc_pkg::SWRC_SETTLE;
      settle_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      if (state != swrc_pkg::SWRC_SETTLE)
        settle_cnt <= '0;
      else if (ref_tick && !settle_done)
        settle_cnt <= settle_cnt + CNT_W'(1);
    end
  end

  // ==========================================================
  // Register file; a pin reset clears everything, a USB reset only the two USB words
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_speed  <= swrc_pkg::CPU_SPEED_RST;
      power_ctrl <= swrc_pkg::POWER_CTRL_RST;
      wake_en    <= swrc_pkg::WAKE_EN_RST;
      irq_mask   <= '0;
      usb_a      <= swrc_pkg::USB_REG_RST;
      usb_b      <= swrc_pkg::USB_REG_RST;
    end
    else
    begin
      if (wr && hit_speed)
        cpu_speed <= (cpu_speed & ~wmask) | (wdat & wmask);
      if (wake_now)
        power_ctrl[swrc_pkg::SLEEP_BIT] <= 1'b0;
      else if (wr && hit_power && state == swrc_pkg::SWRC_RUN)
        power_ctrl <= (power_ctrl & ~wmask) | (wdat & wmask);
      if (wr && hit_wake)
        wake_en <= (wake_en & ~wmask) | (wdat & wmask);
      if (wr && hit_mask && avs_byteenable[0])
        irq_mask <= wdat[swrc_pkg::NUM_WAKE-1:0];
      if (usb_bus_reset)
      begin
        usb_a <= swrc_pkg::USB_REG_RST;
        usb_b <= swrc_pkg::USB_REG_RST;
      end
      else
      begin
        if (wr && hit_usb_a)
          usb_a <= (usb_a & ~wmask) | (wdat & wmask);
        if (wr && hit_usb_b)
          usb_b <= (usb_b & ~wmask) | (wdat & wmask);
      end
    end
  end

  // Sticky wake status per source; a new event beats a write-one clear
  wire logic [swrc_pkg::NUM_WAKE-1:0] next_irq_stat;
  genvar g;
  generate
    for (g = 0; g < swrc_pkg::NUM_WAKE; g++)
    begin : g_stat
      wire logic hit_set = wake_hit[g] & wake_now;
      wire logic clr     = wr && hit_stat && avs_byteenable[0] && wdat[g];
      assign next_irq_stat[g] = hit_set | (irq_stat[g] & ~clr);
    end
  endgenerate

  // One register holds the whole status word, so no bit has two writers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat <= '0;
    else
      irq_stat <= next_irq_stat;
  end

  // Clock source strap caught at the first edge after reset release
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_taken  <= 1'b0;
      ref_is_12mhz <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_taken  <= 1'b1;
      ref_is_12mhz <= clock_source_select;
    end
  end

  // ==========================================================
  // Output next values; taken from next_state so outputs flip on the state edge itself, except the pin snapshot, which resumes one cycle after the wake edge
  wire logic                        asleep        = state == swrc_pkg::SWRC_SLEEP;
  wire logic                        next_awake    = next_state != swrc_pkg::SWRC_SLEEP;
  wire logic                        next_run      = next_state == swrc_pkg::SWRC_RUN;
  wire logic                        pins_follow   = !asleep && next_awake;
  wire logic [swrc_pkg::ADDR_W:0]   next_mem_addr = next_awake ? mem_addr_live : '0;
  wire swrc_pkg::swrc_power_t       next_power_en = swrc_pkg::swrc_power_t'({4{next_awake}});

  // Pin snapshot follows the live configuration while awake and freezes on the sleep edge
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      gpio_cfg_hold <= '0;
    else if (pins_follow)
      gpio_cfg_hold <= gpio_cfg_live;
  end

  // Memory address pins, forced low from the edge that enters sleep
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      mem_addr_out <= '0;
    else
      mem_addr_out <= next_mem_addr;
  end

  // Power domains switch as one; the PLL returns at the wake edge so the settle count times its lock
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      power_en <= '0;
    else
      power_en <= next_power_en;
  end

  // Core release; the boot vector gives way to the firmware start on the same edge as the release
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_run        <= 1'b0;
      cpu_start_addr <= swrc_pkg::BOOT_VECTOR;
    end
    else
    begin
      cpu_run <= next_run;
      if (next_run)
        cpu_start_addr <= swrc_pkg::FIRMWARE_START;
    end
  end

  // Core clock divider copy and level interrupt, one cycle behind their registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_clk_div <= '0;
      irq         <= 1'b0;
    end
    else
    begin
      cpu_clk_div <= cpu_speed[swrc_pkg::CPU_SPEED_W-1:0];
      irq         <= |(irq_stat & irq_mask);
    end
  end

  // ==========================================================
  // Bus answer: one wait cycle, then data and response
  wire logic [15:0] rd_word =
      hit_speed ? cpu_speed :
      hit_power ? power_ctrl :
      hit_wake  ? wake_en :
      hit_stat  ? {8'h00, irq_stat} :
      hit_mask  ? {8'h00, irq_mask} :
      hit_seq   ? {13'h0000, ref_is_12mhz, state} :
      hit_usb_a ? usb_a :
      hit_usb_b ? usb_b : 16'h0000;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_pending    <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      avs_response    <= 2'b00;
    end
    else
    begin
      resp_pending    <= req;
      avs_waitrequest <= ~req;
      if (req)
      begin
        avs_readdata <= {16'h0000, rd_word};
        avs_response <= mapped ? 2'b00 : 2'b11;  // Decode error on unmapped words
      end
    end
  end

endmodule

// file: verif/swrc_checker.sv
// Port-level assertions for the sleep, wakeup and reset sequencer
`timescale 1ns/1ps

module swrc_checker #(
  parameter int SETTLE_TICKS = 4,
  parameter int REF_DIV      = 8,
  parameter int GPIO_W       = 32
)(
  input wire logic                        sys_clk,
  input wire logic                        rst_n,
  input wire logic [swrc_pkg::ADDR_W-1:0] avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [31:0]                 avs_writedata,
  input wire logic [3:0]                  avs_byteenable,
  input wire logic                        avs_waitrequest,
  input wire logic                        usb_bus_reset,
  input wire logic [GPIO_W-1:0]           gpio_cfg_hold,
  input wire logic [swrc_pkg::ADDR_W:0]   mem_addr_out,
  input wire swrc_pkg::swrc_power_t       power_en,
  input wire logic                        cpu_run,
  input wire logic [15:0]                 cpu_start_addr,
  input wire logic [3:0]                  cpu_clk_div
);
  localparam logic [17:0] SPEED_A = {1'b0, swrc_pkg::CPU_SPEED_IDX, 1'b0};
  localparam logic [17:0] POWER_A = {1'b0, swrc_pkg::POWER_CTRL_IDX, 1'b0};

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================
  // Settle counter: cycles powered but not yet running
  int unsigned wait_cnt;
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      wait_cnt <= 0;
    else
      wait_cnt <= (cpu_run || !power_en.pll_en) ? 0 : wait_cnt + 1;

  // ==========================================
  // Accepted writes; only a running core may request sleep
  sequence s_sleep_req;
    avs_write && !avs_waitrequest && avs_address == POWER_A && avs_byteenable[0] && avs_writedata[1] && $past(cpu_run);
  endsequence
  sequence s_speed_wr;
    avs_write && !avs_waitrequest && avs_address == SPEED_A && avs_byteenable[0];
  endsequence

  property p_sleep_entry;
    s_sleep_req |-> ##[1:2] power_en == 4'h0;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
  property p_domains;
    power_en == 4'h0 || power_en == 4'hF;
  endproperty
  a_domains: assert property (p_domains) else $error("power domains split");
  property p_addr_low;
    !power_en.pll_en |-> mem_addr_out == '0;
  endproperty
  a_addr_low: assert property (p_addr_low) else $error("address not low in sleep");
  property p_pins_hold;
    !power_en.pll_en && !$past(power_en.pll_en) && !$past(power_en.pll_en, 2) |-> $stable(gpio_cfg_hold);
  endproperty
  a_pins_hold: assert property (p_pins_hold) else $error("pin config moved in sleep");
  property p_run_power;
    cpu_run |-> power_en == 4'hF;
  endproperty
  a_run_power: assert property (p_run_power) else $error("core runs unpowered");
  property p_settle_max;
    wait_cnt <= (SETTLE_TICKS + 2) * REF_DIV;
  endproperty
  a_settle_max: assert property (p_settle_max) else $error("resume too late");
  property p_settle_min;
    $rose(cpu_run) |-> wait_cnt >= SETTLE_TICKS * REF_DIV;
  endproperty
  a_settle_min: assert property (p_settle_min) else $error("resume before settle");
  property p_start;
    cpu_run |-> cpu_start_addr == swrc_pkg::FIRMWARE_START;
  endproperty
  a_start: assert property (p_start) else $error("wrong start address");
  property p_speed;
    s_speed_wr |=> cpu_clk_div == $past(avs_writedata[3:0]);
  endproperty
  a_speed: assert property (p_speed) else $error("speed write lost");
  property p_usb_keep;
    usb_bus_reset && !avs_write |-> ##2 $stable(cpu_clk_div);
  endproperty
  a_usb_keep: assert property (p_usb_keep) else $error("usb reset hit speed");
  property p_answer;
    avs_read || avs_write |-> ##[0:2] !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer missing");
endmodule

bind swrc_top swrc_checker #(.SETTLE_TICKS(SETTLE_TICKS), .REF_DIV(REF_DIV), .GPIO_W(GPIO_W)) swrc_checker_inst (
  .sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .usb_bus_reset, .gpio_cfg_hold, .mem_addr_out, .power_en, .cpu_run,
  .cpu_start_addr, .cpu_clk_div);

// file: verif/swrc_far_side.sv
// Far-side model: reference tick and the wakeup sources
`timescale 1ns/1ps

module swrc_far_side #(
  parameter int REF_DIV = 8
)(
  input  wire logic [7:0] fire,
  input  wire logic       sys_clk,
  output logic            ref_tick = 1'b0,
  output logic            usb_resume = 1'b0,
  output logic            otg_bus_power_sense = 1'b0,
  output logic            otg_identity_sense = 1'b0,
  output logic            host_port_interface_read = 1'b0,
  output logic            fast_serial_port_read = 1'b0,
  output logic            spi_read = 1'b0,
  output logic            external_irq_one = 1'b0,
  output logic            external_irq_zero = 1'b0
);
  int cnt = 0;

  // ==========================================
  // Oscillator keeps ticking through reset and sleep
  always @(posedge sys_clk)
  begin
    cnt <= (cnt == REF_DIV - 1) ? 0 : cnt + 1;
    ref_tick <= (cnt == REF_DIV - 1);
  end

  // Pulsed sources are high one cycle; edge sources toggle so both edge senses occur
  always @(posedge sys_clk)
  begin
    usb_resume <= fire[swrc_pkg::WK_USB_RESUME];
    otg_bus_power_sense <= fire[swrc_pkg::WK_BUS_POWER];
    otg_identity_sense <= otg_identity_sense ^ fire[swrc_pkg::WK_IDENTITY];
    host_port_interface_read <= fire[swrc_pkg::WK_HPI_READ];
    fast_serial_port_read <= fire[swrc_pkg::WK_FSP_READ];
    spi_read <= fire[swrc_pkg::WK_SPI_READ];
    external_irq_one <= external_irq_one ^ fire[swrc_pkg::WK_IRQ_ONE];
    external_irq_zero <= external_irq_zero ^ fire[swrc_pkg::WK_IRQ_ZERO];
  end
endmodule

// file: verif/swrc_top_tb_top.sv
// Self-checking bench for the sleep, wakeup and reset sequencer
`timescale 1ns/1ps

module swrc_top_tb_top;
  localparam int ST = 4;
  localparam int RD = 8;
  logic sys_clk, rst_n, avs_read, avs_write, clock_source_select, usb_bus_reset, avs_waitrequest;
  logic ref_tick, usb_resume, otg_bus_power_sense, otg_identity_sense, spi_read, cpu_run, irq;
  logic host_port_interface_read, fast_serial_port_read, external_irq_one, external_irq_zero, ref_is_12mhz;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, gpio_cfg_live, gpio_cfg_hold;
  logic [18:0] mem_addr_live, mem_addr_out;
  logic [15:0] cpu_start_addr, rdat;
  logic [3:0]  avs_byteenable, cpu_clk_div;
  logic [1:0]  avs_response, resp;
  logic [7:0]  fire;
  swrc_pkg::swrc_power_t power_en;
  int errors, compares;

  swrc_top #(.SETTLE_TICKS(ST), .REF_DIV(RD)) swrc_top_inst (.*);
  swrc_far_side #(.REF_DIV(RD)) swrc_far_side_inst (.*);

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon cycle; request held until waitrequest is seen low, a lost answer is left to the watchdog
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
    @(posedge sys_clk);
    avs_address <= {1'b0, idx, 1'b0};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {16'h0000, wd};
    do
      @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata[15:0];
    resp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Resume must land between the settle count and its bound
  task automatic wait_run();
    int n;
    n = 0;
    while (cpu_run !== 1'b1 && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(n >= ST * RD && n <= (ST + 2) * RD), 32'h0000_0001);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_boot();
    chk(32'(cpu_start_addr), 32'h0000_FF00);
    wait_run();
    chk(32'(ref_is_12mhz), 32'h0000_0001);
    chk(32'(cpu_start_addr), 32'h0000_E000);
    bus(1'b0, swrc_pkg::SEQ_STAT_IDX, 16'h0000);
    chk(32'(rdat), 32'h0000_0005);
    bus(1'b0, swrc_pkg::POWER_CTRL_IDX, 16'h0000);
    chk(32'(rdat), 32'h0000_0000);
    bus(1'b0, swrc_pkg::WAKE_EN_IDX, 16'h0000);
    chk(32'(rdat), 32'h0000_0000);
  endtask

  task automatic t_regs();
    bus(1'b1, swrc_pkg::CPU_SPEED_IDX, 16'h0005);
    @(posedge sys_clk);
    chk(32'(cpu_clk_div), 32'h0000_0005);
    bus(1'b1, swrc_pkg::USB_A_IDX, 16'h1234);
    bus(1'b1, swrc_pkg::USB_B_IDX, 16'h5678);
    usb_bus_reset <= 1'b1;
    @(posedge sys_clk);
    usb_bus_reset <= 1'b0;
    bus(1'b0, swrc_pkg::CPU_SPEED_IDX, 16'h0000);
    chk(32'(rdat), 32'h0000_0005);
    bus(1'b0, swrc_pkg::USB_A_IDX, 16'h0000);
    chk(32'(rdat), 32'h0000_0000);
    bus(1'b0, swrc_pkg::USB_B_IDX, 16'h0000);
    chk(32'(rdat), 32'h0000_0000);
    bus(1'b0, 16'hC100, 16'h0000);
    chk({resp, rdat}, 32'h0003_0000);
  endtask

  task automatic t_sleep(input int i);
    logic [31:0] p;
    p = gpio_cfg_live;
    bus(1'b1, swrc_pkg::WAKE_EN_IDX, 16'(1 << i));
    bus(1'b1, swrc_pkg::IRQ_MASK_IDX, 16'h00FF);
    bus(1'b1, swrc_pkg::POWER_CTRL_IDX, 16'h0002);
    repeat (3) @(posedge sys_clk);
    gpio_cfg_live <= ~p;
    fire <= 8'(1 << ((i + 1) % 8));
    @(posedge sys_clk);
    fire <= 8'h00;
    repeat (8) @(posedge sys_clk);
    chk(32'(power_en), 32'h0000_0000);
    chk(32'(mem_addr_out), 32'h0000_0000);
    chk(gpio_cfg_hold, p);
    chk(32'(cpu_run), 32'h0000_0000);
    fire <= 8'(1 << i);
    @(posedge sys_clk);
    fire <= 8'h00;
    wait_run();
    bus(1'b0, swrc_pkg::IRQ_STAT_IDX, 16'h0000);
    chk(32'(rdat[i]), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    bus(1'b0, swrc_pkg::POWER_CTRL_IDX, 16'h0000);
    chk(32'(rdat[1]), 32'h0000_0000);
    bus(1'b1, swrc_pkg::IRQ_MASK_IDX, 16'h0000);
    @(posedge sys_clk);
    chk(32'(irq), 32'h0000_0000);
    bus(1'b1, swrc_pkg::IRQ_MASK_IDX, 16'(1 << i));
    bus(1'b1, swrc_pkg::IRQ_STAT_IDX, 16'(1 << i));
    @(posedge sys_clk);
    chk(32'(irq), 32'h0000_0000);
  endtask

  task automatic t_pin_reset();
    bus(1'b1, swrc_pkg::CPU_SPEED_IDX, 16'h000A);
    rst_n <= 1'b0;
    repeat (16 * RD) @(posedge sys_clk);
    chk(32'(cpu_start_addr), 32'h0000_FF00);
    rst_n <= 1'b1;
    wait_run();
    bus(1'b0, swrc_pkg::CPU_SPEED_IDX, 16'h0000);
    chk(32'(rdat), 32'h0000_0000);
  endtask

  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    {errors, compares} = 0;
    {rst_n, avs_read, avs_write, usb_bus_reset} = 4'h0;
    {avs_address, avs_writedata, fire} = '0;
    avs_byteenable = 4'h3;
    clock_source_select = 1'b1;
    gpio_cfg_live = 32'h5A5A_0F0F;
    mem_addr_live = 19'h5_1234;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_boot();
    t_regs();
    for (int i = 0; i < 8; i++)
      t_sleep(i);
    t_pin_reset();
    summarize();
  end

  initial
  begin
    #100000;
    errors++;
    summarize();
  end
endmodule
